// file: hdl/vfr_top.sv
/*
  Input-voltage fault response block: holds the overvoltage fault action, the
  fault threshold and both warning thresholds, watches the measured input
  voltage, drives the output enable and the active-low alert line.
  Assumes the command decoder and the voltage measurement share clk_i; the
  control pin and bias-good pin are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module vfr_top #(
  parameter int RETRY_STEP_CYCLES = vfr_pkg::VFR_RETRY_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command port from the PMBus decoder
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic clear_status_i,
  output logic rsp_valid_o,
  output logic rsp_error_o,
  output logic [15:0] rsp_rdata_o,
  // Measurement and on/off sources
  input wire logic [15:0] vin_i,
  input wire logic operation_on_i,
  input wire logic other_fault_i,
  input wire logic ctrl_pin_i,
  input wire logic bias_good_i,
  // Power stage and alert
  output logic output_enable_o,
  output logic alert_line_n_o,
  output logic [2:0] status_o
);
  import vfr_pkg::*;

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (RETRY_STEP_CYCLES < 1) begin : g_bad_step
    $error("RETRY_STEP_CYCLES must be at least one");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ctrl_sync;    // Control pin synchroniser
    logic [1:0] bias_sync;    // Bias-good synchroniser
    logic [15:0] fault_lim;   // Overvoltage fault threshold
    logic [7:0] action;       // Fault action byte
    logic [15:0] ov_warn;     // Overvoltage warning threshold
    logic [15:0] uv_warn;     // Undervoltage warning threshold
    logic ov_active;          // Fault present, held by hysteresis
    logic [2:0] status;       // Sticky status bits
    vfr_state_t state;        // Output control state
    logic [31:0] tick;        // Cycles within one retry step
    logic [2:0] steps;        // Retry steps elapsed
    logic out_en;             // Output enable flop
    logic alert_n;            // Alert flop
    logic rsp_valid;          // Response strobe
    logic rsp_error;          // Response error
    logic [15:0] rsp_data;    // Read data
  } vfr_regs_t;

  localparam vfr_regs_t VFR_RESET = '{
    ctrl_sync: 2'h0, bias_sync: 2'h0,
    fault_lim: VFR_RST_OV_FAULT_LIMIT,
    action: VFR_RST_OV_ACTION,
    ov_warn: VFR_RST_OV_WARN,
    uv_warn: VFR_RST_UV_WARN,
    ov_active: 1'b0, status: 3'h0, state: VFR_OFF,
    tick: 32'h0, steps: 3'h0, out_en: 1'b0, alert_n: 1'b1,
    rsp_valid: 1'b0, rsp_error: 1'b0, rsp_data: 16'h0
  };

  vfr_regs_t s_reg;   // Registered state
  vfr_regs_t s_next;  // Next state

  // Decoded fields of the action byte
  logic [1:0] fault_action_select;
  logic [2:0] retry_sel;
  logic [2:0] delay_sel;
  // Signed views for comparison
  logic signed [16:0] vin_s;
  logic signed [16:0] lim_s;
  logic signed [16:0] clear_s;
  logic ov_over;
  logic ov_below_clear;
  logic ov_event;
  logic run_ok;
  logic step_done;
  logic page_ok;

  assign fault_action_select = s_reg.action[VFR_ACT_MSB:VFR_ACT_LSB];
  assign retry_sel = s_reg.action[VFR_RETRY_MSB:VFR_RETRY_LSB];
  assign delay_sel = s_reg.action[VFR_DELAY_MSB:VFR_DELAY_LSB];

  // ------------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------------
  // All thresholds are two's complement, so compare signed
  assign vin_s = 17'($signed(vin_i));
  assign lim_s = 17'($signed(s_reg.fault_lim));
  // Clear level is the threshold less a sixteenth of it
  assign clear_s = lim_s - (lim_s >>> VFR_HYST_SHIFT);
  assign ov_over = vin_s > lim_s;
  assign ov_below_clear = vin_s < clear_s;
  assign ov_event = ov_over && !s_reg.ov_active;
  // Commanded on through both the pin and the operation command, with bias
  assign run_ok = s_reg.ctrl_sync[1] && s_reg.bias_sync[1] && operation_on_i && !other_fault_i;
  assign step_done = s_reg.tick == 32'(RETRY_STEP_CYCLES - 1);
  // Only page zero addresses the single channel
  assign page_ok = cmd_page_i == VFR_PAGE_ONLY;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Pins pass two flops before use
    s_next.ctrl_sync = {s_reg.ctrl_sync[0], ctrl_pin_i};
    s_next.bias_sync = {s_reg.bias_sync[0], bias_good_i};
    s_next.rsp_valid = 1'b0;

    // Command handling: one response per strobe, a cycle later
    if (cmd_valid_i) begin
      s_next.rsp_valid = 1'b1;
      s_next.rsp_error = 1'b0;
      s_next.rsp_data = 16'h0;
      if (!page_ok) begin
        // Wrong page: refused, nothing stored
        s_next.rsp_error = 1'b1;
      end else begin
        case (cmd_code_i)
          VFR_CMD_OV_FAULT_LIMIT: begin
            s_next.rsp_data = s_reg.fault_lim;
            if (cmd_write_i) begin
              s_next.fault_lim = cmd_wdata_i;
            end
          end
          VFR_CMD_OV_ACTION: begin
            // Byte register, upper bits read zero
            s_next.rsp_data = {8'h0, s_reg.action};
            if (cmd_write_i) begin
              s_next.action = cmd_wdata_i[7:0];
            end
          end
          VFR_CMD_OV_WARN: begin
            s_next.rsp_data = s_reg.ov_warn;
            if (cmd_write_i) begin
              s_next.ov_warn = cmd_wdata_i;
            end
          end
          VFR_CMD_UV_WARN: begin
            s_next.rsp_data = s_reg.uv_warn;
            if (cmd_write_i) begin
              s_next.uv_warn = cmd_wdata_i;
            end
          end
          default: begin
            // Unknown code answers with an error
            s_next.rsp_error = 1'b1;
          end
        endcase
      end
    end

    // Fault presence with hysteresis
    if (ov_event) begin
      s_next.ov_active = 1'b1;
    end else if (s_reg.ov_active && ov_below_clear) begin
      s_next.ov_active = 1'b0;
    end

    // Sticky status: clear first so that a same-cycle set wins
    if (clear_status_i) begin
      s_next.status = 3'h0;
    end
    if (ov_event) begin
      s_next.status[VFR_ST_OV_FAULT] = 1'b1;
    end
    if (vin_s > 17'($signed(s_reg.ov_warn))) begin
      s_next.status[VFR_ST_OV_WARN] = 1'b1;
    end
    // A zero undervoltage threshold never trips
    if (s_reg.uv_warn != 16'h0 && vin_s < 17'($signed(s_reg.uv_warn))) begin
      s_next.status[VFR_ST_UV_WARN] = 1'b1;
    end

    // Output control
    case (s_reg.state)
      VFR_OFF: begin
        // A fault still present blocks start only when it would disable.
        // A fault arriving this very cycle blocks too: once active it raises no
        // further event, so a started output would never be disabled.
        if (run_ok && !((s_reg.ov_active || ov_event) && fault_action_select == VFR_ACT_DISABLE)) begin
          s_next.state = VFR_RUN;
        end
      end
      VFR_RUN: begin
        if (!run_ok) begin
          s_next.state = VFR_OFF;
        end else if (ov_event && fault_action_select == VFR_ACT_DISABLE) begin
          // Disable, then follow the retry field
          s_next.tick = 32'h0;
          s_next.steps = 3'h0;
          if (retry_sel == VFR_RETRY_FOREVER) begin
            s_next.state = VFR_RETRY;
          end else begin
            // Unsupported codes behave as no retry
            s_next.state = VFR_LATCHED;
          end
        end
        // Continue and unsupported actions leave the output on
      end
      VFR_LATCHED: begin
        // Held off until the channel is commanded off to restart
        if (!run_ok) begin
          s_next.state = VFR_OFF;
        end
      end
      VFR_RETRY: begin
        if (!run_ok) begin
          // Off command, lost bias or another fault ends retrying
          s_next.state = VFR_OFF;
        end else if (s_reg.steps >= delay_sel) begin
          // Delay spent: restart once the fault has cleared
          // A fresh fault in the same cycle must not restart the output
          if (!s_reg.ov_active && !ov_event) begin
            s_next.state = VFR_RUN;
          end
        end else if (step_done) begin
          s_next.tick = 32'h0;
          s_next.steps = s_reg.steps + 3'h1;
        end else begin
          s_next.tick = s_reg.tick + 32'h1;
        end
      end
      default: begin
        s_next.state = VFR_OFF;
      end
    endcase

    // Output flops follow the next state
    s_next.out_en = s_next.state == VFR_RUN;
    // Alert stays low while any status bit stands
    s_next.alert_n = ~|s_next.status;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= VFR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs straight from flops
  // ------------------------------------------------------------------
  assign rsp_valid_o = s_reg.rsp_valid;
  assign rsp_error_o = s_reg.rsp_error;
  assign rsp_rdata_o = s_reg.rsp_data;
  assign output_enable_o = s_reg.out_en;
  assign alert_line_n_o = s_reg.alert_n;
  assign status_o = s_reg.status;

endmodule

// file: shared/vfr_pkg.sv
/*
  Shared constants for the input-voltage fault response block: command codes,
  register reset values, field positions, encodings and retry timing.
  Assumes a 250 MHz core clock and a command decoder that hands over whole
  PMBus commands, one per strobe.
*/
package vfr_pkg;

  // ------------------------------------------------------------------
  // Command codes and paging
  // ------------------------------------------------------------------
  localparam logic [7:0] VFR_CMD_OV_FAULT_LIMIT = 8'h55; // Fault threshold
  localparam logic [7:0] VFR_CMD_OV_ACTION = 8'h56;      // Fault action byte
  localparam logic [7:0] VFR_CMD_OV_WARN = 8'h57;        // Overvoltage warning
  localparam logic [7:0] VFR_CMD_UV_WARN = 8'h58;        // Undervoltage warning
  localparam logic [7:0] VFR_PAGE_ONLY = 8'h00;          // Single channel page

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] VFR_RST_OV_FAULT_LIMIT = 16'h0640;
  localparam logic [7:0] VFR_RST_OV_ACTION = 8'h84;
  localparam logic [15:0] VFR_RST_OV_WARN = 16'h0708;
  localparam logic [15:0] VFR_RST_UV_WARN = 16'h0000;

  // ------------------------------------------------------------------
  // Fault action byte fields and codes
  // ------------------------------------------------------------------
  localparam int VFR_ACT_MSB = 7;
  localparam int VFR_ACT_LSB = 6;
  localparam int VFR_RETRY_MSB = 5;
  localparam int VFR_RETRY_LSB = 3;
  localparam int VFR_DELAY_MSB = 2;
  localparam int VFR_DELAY_LSB = 0;
  localparam logic [1:0] VFR_ACT_CONTINUE = 2'h0;
  localparam logic [1:0] VFR_ACT_DISABLE = 2'h2;
  localparam logic [2:0] VFR_RETRY_NONE = 3'h0;
  localparam logic [2:0] VFR_RETRY_FOREVER = 3'h7;

  // Hysteresis: fault clears one sixteenth below the threshold
  localparam int VFR_HYST_SHIFT = 4;

  // Status bit positions
  localparam int VFR_ST_OV_FAULT = 0;
  localparam int VFR_ST_OV_WARN = 1;
  localparam int VFR_ST_UV_WARN = 2;

  // ------------------------------------------------------------------
  // Retry timing
  // ------------------------------------------------------------------
  localparam int VFR_CLK_MHZ = 250;
  localparam int VFR_RETRY_STEP_MS = 25;   // Per delay code count
  localparam int VFR_RETRY_MAX_MS = 175;   // Delay code 7
  localparam int VFR_RETRY_STEP_CYCLES = VFR_RETRY_STEP_MS * VFR_CLK_MHZ * 1000;
  localparam logic [2:0] VFR_RETRY_MAX_STEPS = 3'(VFR_RETRY_MAX_MS / VFR_RETRY_STEP_MS);

  // ------------------------------------------------------------------
  // Output control states, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    VFR_OFF = 4'b0001,      // Commanded off or not yet started
    VFR_RUN = 4'b0010,      // Output enabled
    VFR_LATCHED = 4'b0100,  // Disabled by fault, no retry
    VFR_RETRY = 4'b1000     // Disabled by fault, waiting to restart
  } vfr_state_t;

endpackage

// file: verification/vfr_top_assertions.sv
/*
  Port checker for vfr_top: command answers, status, alert and enable.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module vfr_top_assertions
  import vfr_pkg::*;
#(
  parameter int RETRY_STEP_CYCLES = VFR_RETRY_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic clear_status_i,
  input wire logic rsp_valid_o,
  input wire logic rsp_error_o,
  input wire logic [15:0] rsp_rdata_o,
  // Measurement, power stage, alert
  input wire logic [15:0] vin_i,
  input wire logic other_fault_i,
  input wire logic output_enable_o,
  input wire logic alert_line_n_o,
  input wire logic [2:0] status_o
);
  // ------------------------------------------------------------
  // Shadow of warning thresholds and action byte, kept from page-zero writes
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ov; // Overvoltage warning
    logic [15:0] uv; // Undervoltage warning
    logic [7:0] act; // Fault action byte
  } vfr_chk_t;
  vfr_chk_t sh_reg; // Registered shadow
  vfr_chk_t sh_next; // Its next value
  logic wr_ok; // Write the block will store
  assign wr_ok = cmd_valid_i && cmd_write_i && cmd_page_i == VFR_PAGE_ONLY;
  // Follow writes the way the block stores them
  always_comb begin
    sh_next = sh_reg;
    if (wr_ok && cmd_code_i == VFR_CMD_OV_WARN)
      sh_next.ov = cmd_wdata_i;
    if (wr_ok && cmd_code_i == VFR_CMD_UV_WARN)
      sh_next.uv = cmd_wdata_i;
    if (wr_ok && cmd_code_i == VFR_CMD_OV_ACTION)
      sh_next.act = cmd_wdata_i[7:0];
  end
  // Register the shadow
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      sh_reg <= {VFR_RST_OV_WARN, VFR_RST_UV_WARN, VFR_RST_OV_ACTION};
    else
      sh_reg <= sh_next;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_rsp_timing: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("no answer one cycle after a command");
  chk_bad_page: assert property (cmd_valid_i && cmd_page_i != VFR_PAGE_ONLY |=>
    rsp_error_o && rsp_rdata_o == 16'h0000) else $error("nonzero page not refused");
  chk_alert_status: assert property (|status_o |-> !alert_line_n_o)
    else $error("status set but alert high");
  chk_ov_warn_set: assert property ($signed(vin_i) > $signed(sh_reg.ov) |=> status_o[1])
    else $error("overvoltage warning not set");
  chk_uv_warn_set: assert property (sh_reg.uv != 0 && $signed(vin_i) < $signed(sh_reg.uv) |=>
    status_o[2]) else $error("undervoltage warning not set");
  chk_uv_disabled: assert property (sh_reg.uv == 0 && !status_o[2] |=> !status_o[2])
    else $error("undervoltage warning with zero threshold");
  chk_status_sticky: assert property (!clear_status_i |=>
    (status_o & $past(status_o)) == $past(status_o)) else $error("status dropped without clear");
  chk_fault_disable: assert property ($rose(status_o[0]) && sh_reg.act[7:6] == VFR_ACT_DISABLE
    |-> !output_enable_o) else $error("output kept on after disabling fault");
  chk_other_off: assert property (other_fault_i [*3] |-> !output_enable_o)
    else $error("output on during other fault");
  // Main scenarios reached
  cover property ($rose(status_o[0]));
  cover property ($rose(output_enable_o) && sh_reg.act[5:3] == VFR_RETRY_FOREVER);
  cover property (rsp_valid_o && rsp_error_o);
endmodule

bind vfr_top vfr_top_assertions #(.RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)) vfr_top_assertions_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
  .cmd_page_i(cmd_page_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
  .clear_status_i(clear_status_i), .rsp_valid_o(rsp_valid_o), .rsp_error_o(rsp_error_o),
  .rsp_rdata_o(rsp_rdata_o), .vin_i(vin_i), .other_fault_i(other_fault_i),
  .output_enable_o(output_enable_o), .alert_line_n_o(alert_line_n_o), .status_o(status_o));

// file: verification/vfr_host.sv
/*
  Host stand-in: issues one whole command per call on the decoder port.
  Assumes the answer strobe rises at the taken edge and stands for one cycle.
*/
`timescale 1ns/1ps
module vfr_host (
  // Clock
  input wire logic clk_i,
  // Request
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_page_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_wdata_o,
  // Answer
  input wire logic rsp_valid_i,
  input wire logic rsp_error_i,
  input wire logic [15:0] rsp_rdata_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_page_o = 8'h00;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end
  // One command: raise after a falling edge, taken at the next rising edge
  task automatic xfer(input logic wr, input logic [7:0] pg, input logic [7:0] cd,
                      input logic [15:0] wd, output logic [15:0] rd, output logic er, output logic vd);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_page_o = pg;
    cmd_code_o = cd;
    cmd_wdata_o = wd;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    // Released lines show the inverse so stale data cannot pass
    cmd_page_o = ~pg;
    cmd_code_o = ~cd;
    cmd_wdata_o = ~wd;
    // Answer stands through this half cycle: take data while the strobe is up
    vd = rsp_valid_i;
    rd = rsp_rdata_i;
    er = rsp_error_i;
    @(negedge clk_i);
    // The strobe must have dropped again after exactly one cycle
    vd = vd && !rsp_valid_i;
  endtask
endmodule

// file: verification/testbench.sv
/*
  Self-checking bench for vfr_top: registers, fault actions, retry, warnings.
  Assumes the host model in vfr_host and a short retry step for speed.
*/
`timescale 1ns/1ps
module testbench;
  import vfr_pkg::*;
  // ------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------
  localparam int STEP = 4; // Short retry step keeps the run brief
  logic clk, rst_n = 1'b0, clr = 1'b0, op_on = 1'b1, ofault = 1'b0, cv, cw, rv, re, oe, al_n;
  logic ctrl = 1'b1, bias = 1'b1; // Control pin and bias-good pin
  logic [7:0] pg, cd;
  logic [15:0] wd, rdat, vin = 16'h04B0, rd;
  logic [2:0] st;
  logic er, vd;
  int num_errors = 0, n_checks = 0, cycles = 0;
  vfr_top #(.RETRY_STEP_CYCLES(STEP)) vfr_top_i (.clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cv),
    .cmd_write_i(cw), .cmd_page_i(pg), .cmd_code_i(cd), .cmd_wdata_i(wd), .clear_status_i(clr),
    .rsp_valid_o(rv), .rsp_error_o(re), .rsp_rdata_o(rdat), .vin_i(vin), .operation_on_i(op_on),
    .other_fault_i(ofault), .ctrl_pin_i(ctrl), .bias_good_i(bias), .output_enable_o(oe),
    .alert_line_n_o(al_n), .status_o(st));
  vfr_host vfr_host_i (.clk_i(clk), .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_page_o(pg),
    .cmd_code_o(cd), .cmd_wdata_o(wd), .rsp_valid_i(rv), .rsp_error_i(re), .rsp_rdata_i(rdat));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard: far beyond the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    vfr_host_i.xfer(1'b1, VFR_PAGE_ONLY, c, d, rd, er, vd);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
    vfr_host_i.xfer(1'b0, VFR_PAGE_ONLY, c, 16'h0000, rd, er, vd);
    check("answer pulse", {15'h0, vd}, 16'h0001);
    check("read data", rd, exp);
  endtask
  // Drive the input voltage, then let n cycles pass
  task automatic vstep(input logic [15:0] v, input int n);
    @(negedge clk);
    vin = v;
    repeat (n) @(negedge clk);
  endtask
  task automatic outs(input logic [2:0] s, input logic e);
    check("status", {13'h0, st}, {13'h0, s});
    check("alert", {15'h0, al_n}, {15'h0, s == 3'h0});
    check("enable", {15'h0, oe}, {15'h0, e});
  endtask
  task automatic clear_all;
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd_chk(VFR_CMD_OV_FAULT_LIMIT, 16'h0640);
    rd_chk(VFR_CMD_OV_ACTION, 16'h0084);
    rd_chk(VFR_CMD_OV_WARN, 16'h0708);
    rd_chk(VFR_CMD_UV_WARN, 16'h0000);
    outs(3'h0, 1'b1);
  endtask
  task automatic t_regs;
    wr(VFR_CMD_OV_WARN, 16'h7FFF);
    check("old value", rd, 16'h0708);
    rd_chk(VFR_CMD_OV_WARN, 16'h7FFF);
    wr(VFR_CMD_OV_ACTION, 16'hABC5);
    rd_chk(VFR_CMD_OV_ACTION, 16'h00C5);
    vfr_host_i.xfer(1'b1, 8'h01, VFR_CMD_OV_WARN, 16'h1234, rd, er, vd);
    check("page refused", {15'h0, er}, 16'h0001);
    rd_chk(VFR_CMD_OV_WARN, 16'h7FFF);
    wr(VFR_CMD_OV_ACTION, 16'h0084);
  endtask
  task automatic t_latch;
    vstep(16'h0641, 3);
    outs(3'h1, 1'b0);
    vstep(16'h04B0, 20);
    outs(3'h1, 1'b0);
    op_on = 1'b0;
    vstep(16'h04B0, 5);
    op_on = 1'b1;
    vstep(16'h04B0, 10);
    check("restart", {15'h0, oe}, 16'h0001);
    clear_all();
    outs(3'h0, 1'b1);
  endtask
  task automatic t_retry;
    wr(VFR_CMD_OV_ACTION, 16'h00BA);
    vstep(16'h0641, 1);
    vstep(16'h05DC, 20);
    check("inside band", {15'h0, oe}, 16'h0000);
    vstep(16'h05DB, 16);
    check("below band", {15'h0, oe}, 16'h0001);
    vstep(16'h0641, 1);
    vstep(16'h05DB, 5);
    check("retry wait", {15'h0, oe}, 16'h0000);
    vstep(16'h05DB, 10);
    check("retry done", {15'h0, oe}, 16'h0001);
    // Control pin off during the retry wait ends retrying
    vstep(16'h0641, 1);
    ctrl = 1'b0;
    vstep(16'h05DB, 15);
    check("pin off", {15'h0, oe}, 16'h0000);
    ctrl = 1'b1;
    vstep(16'h05DB, 6);
    check("pin on", {15'h0, oe}, 16'h0001);
    // Lost bias power turns the output off
    bias = 1'b0;
    vstep(16'h05DB, 5);
    check("bias off", {15'h0, oe}, 16'h0000);
    bias = 1'b1;
    vstep(16'h05DB, 6);
    check("bias on", {15'h0, oe}, 16'h0001);
    ofault = 1'b1;
    vstep(16'h05DB, 20);
    check("forced off", {15'h0, oe}, 16'h0000);
    ofault = 1'b0;
    clear_all();
  endtask
  task automatic t_continue;
    wr(VFR_CMD_OV_ACTION, 16'h0000);
    vstep(16'h0641, 3);
    outs(3'h1, 1'b1);
    vstep(16'h04B0, 2);
    clear_all();
    outs(3'h0, 1'b1);
  endtask
  task automatic t_warn;
    wr(VFR_CMD_OV_FAULT_LIMIT, 16'h0800);
    wr(VFR_CMD_OV_WARN, 16'h0708);
    vstep(16'h0709, 3);
    outs(3'h2, 1'b1);
    vstep(16'h0000, 2);
    clear_all();
    outs(3'h0, 1'b1);
    wr(VFR_CMD_UV_WARN, 16'h0400);
    vstep(16'h03FF, 3);
    outs(3'h4, 1'b1);
    vstep(16'h0400, 2);
    clear_all();
    outs(3'h0, 1'b1);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence: reset for 10 cycles, then every scenario
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_reset();
    t_regs();
    t_latch();
    t_retry();
    t_continue();
    t_warn();
    complete_run();
  end
endmodule
